// ---- src/mids_pkg.sv ----
// shared constants and types of the module id and diagnostics slave
package mids_pkg;
   // ***********************
   // slave addresses, pages
   // ***********************
   localparam logic [6:0] ID_DEV_ADDR = 7'h50;
   localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
   localparam logic PAGE_ID = 1'b0;
   localparam logic PAGE_DIAG = 1'b1;
   // ***********************
   // diagnostic page layout, id page calibration byte
   // ***********************
   localparam logic [7:0] OFS_THR_END = 8'h28;
   localparam logic [7:0] OFS_LIVE = 8'h60;
   localparam logic [7:0] OFS_LIVE_END = 8'h6a;
   localparam logic [7:0] OFS_STATUS = 8'h6e;
   localparam logic [7:0] OFS_ALARM = 8'h70;
   localparam logic [7:0] OFS_WARN = 8'h74;
   localparam logic [7:0] OFS_RO_END = 8'h80;
   localparam logic [7:0] OFS_CAL_TYPE = 8'h5c;
   localparam logic [7:0] CAL_INT_MASK = 8'h20;
   localparam int STAT_TXDIS_BIT = 7;
   localparam int STAT_LOS_BIT = 1;
   localparam int NUM_MON = 5;
   localparam int THR_BYTES = 40;
   localparam int THR_STRIDE = 8;
   localparam int THR_HI_ALARM = 0;
   localparam int THR_LO_ALARM = 2;
   localparam int THR_HI_WARN = 4;
   localparam int THR_LO_WARN = 6;
   // ***********************
   // bit counting, reset values
   // ***********************
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // order {scl, sda, tx_disable, rx_sig_det, id_wp}
   localparam logic [4:0] SYNC_RST = 5'h1c;
   // ***********************
   // timing
   // ***********************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TX_OFF_US = 10;
   localparam int TX_OFF_CYC = TX_OFF_US * 1000000 / CLK_PERIOD_PS;
   localparam int TX_CNT_W = 12;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_PTR = 3'b010,
      ST_WR = 3'b011,
      ST_RD = 3'b100
   } mids_state_t;
   // live values, status and flags are never stored by a write
   function automatic logic is_protected(input logic page, input logic [7:0] ofs, input logic wp);
      return (page == PAGE_ID) ? wp : (ofs >= OFS_LIVE && ofs < OFS_RO_END);
   endfunction : is_protected
endpackage : mids_pkg

// ---- src/mids_link_if.sv ----
// signals between the core and the serial clock domain
`timescale 1ns/1ps
interface mids_link_if;
   logic [7:0] rx_byte;
   logic drive_req;
   modport link (output rx_byte, input drive_req);
   modport core (input rx_byte, output drive_req);
endinterface : mids_link_if

// ---- src/mids_link.sv ----
// serial clock domain: bit capture and data line driver
`timescale 1ns/1ps
module mids_link
   import mids_pkg::*;
(
   // link clock and pin
   input wire logic scl_clk,
   input wire logic rstn,
   input wire logic sda_in,
   // core side
   mids_link_if.link lk,
   // open-drain enable, low pulls the line down
   output logic sda_oe_n
);
   // ***********************
   // capture
   // ***********************
   // core reads this only two to three clk periods after the edge, so it is settled
   always_ff @(posedge scl_clk or negedge rstn) begin
      if (!rstn) begin
         lk.rx_byte <= 8'h00;
      end else begin
         lk.rx_byte <= {lk.rx_byte[6:0], sda_in};
      end
   end
   // ***********************
   // driver
   // ***********************
   // drive_req is set at a rising edge, long before the falling one
   always_ff @(negedge scl_clk or negedge rstn) begin
      if (!rstn) begin
         sda_oe_n <= 1'b1;
      end else begin
         sda_oe_n <= ~lk.drive_req;
      end
   end
endmodule : mids_link

// ---- src/mids_mem.sv ----
// two byte pages of storage with registered read
`timescale 1ns/1ps
module mids_mem (
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [8:0] waddr,
   input wire logic [7:0] wdata,
   // read port
   input wire logic [8:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem_q [512];
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end
   always_ff @(posedge clk) begin
      rdata <= mem_q[raddr];
   end
endmodule : mids_mem

// ---- src/mids_top.sv ----
// module id and diagnostics two-wire slave, top level
//
// What this block does
// - answers device address 1010000x with the 256-byte identification page.
// - answers device address 1010001x with the diagnostic page, id page untouched.
// - serial bits are captured at rising clock edges, writes skip protected bytes.
// - read bits change on the data line at falling clock edges.
// - both pages are bytes, read or written singly or in runs with auto increment.
// - live temperature, bias, tx power, rx power and supply show on the diagnostic page.
// - alarm and warning flags rise when a live value leaves its programmed range.
// - the signal lost output is 1 with no received signal and 0 otherwise.
// - the laser turns off within 10 us of transmit disable going high.
// - diagnostic values are reported already calibrated.
// - the identification page is readable by the host.
// - the laser is off while transmit disable is high and on only while it is low.
// - the presence pin is held low.
`timescale 1ns/1ps
module mids_top
   import mids_pkg::*;
(
   // clocks and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_clk,
   // serial data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // pins and straps
   input wire logic tx_disable,
   input wire logic rx_sig_det,
   input wire logic id_wp,
   // calibrated monitor values
   input wire logic [15:0] mon_temp,
   input wire logic [15:0] mon_vcc,
   input wire logic [15:0] mon_bias,
   input wire logic [15:0] mon_txpwr,
   input wire logic [15:0] mon_rxpwr,
   // status outputs
   output logic signal_lost_flag,
   output logic tx_laser_en,
   output logic presence_pin_out,
   output logic presence_pin_oe_n
);
   // ***********************
   // declarations
   // ***********************
   mids_link_if lk ();
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic [1:0] prev_q;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic bus_start;
   logic bus_stop;
   mids_state_t state_q;
   logic [3:0] bc_q;
   logic page_q;
   logic rw_q;
   logic [7:0] ptr_q;
   logic [7:0] tx_q;
   logic drive_req_q;
   logic we_q;
   logic [8:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic [7:0] mem_rdata;
   logic [7:0] rd_val;
   logic [7:0] live_off;
   logic [7:0] status_byte;
   logic [15:0] live_q [NUM_MON];
   logic [7:0] thr_q [THR_BYTES];
   logic [15:0] alarm_q;
   logic [15:0] warn_q;
   logic [TX_CNT_W-1:0] txoff_cnt_q;
   logic [7:0] rx;
   logic active;
   logic bit_phase;
   logic byte_done;
   logic ack_phase;
   logic addr_hit;
   logic load_rd;

   function automatic logic [15:0] thr16(input int idx);
      return {thr_q[idx], thr_q[idx + 1]};
   endfunction : thr16

   // ***********************
   // pin synchronisers
   // ***********************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
         prev_q <= 2'h3;
      end else begin
         meta_q <= {scl_clk, sda_in, tx_disable, rx_sig_det, id_wp};
         sync_q <= meta_q;
         prev_q <= sync_q[4:3];
      end
   end
   assign scl_s = sync_q[4];
   assign sda_s = sync_q[3];
   assign scl_rise = scl_s & ~prev_q[1];
   // both lines pass equal delay, so start and stop keep their order
   assign bus_start = scl_s & prev_q[1] & prev_q[0] & ~sda_s;
   assign bus_stop = scl_s & prev_q[1] & ~prev_q[0] & sda_s;

   mids_link u_link (
      .scl_clk(scl_clk),
      .rstn(rstn),
      .sda_in(sda_in),
      .lk(lk.link),
      .sda_oe_n(sda_oe_n)
   );
   assign lk.drive_req = drive_req_q;
   assign rx = lk.rx_byte;

   // ***********************
   // byte framing
   // ***********************
   assign active = scl_rise & (state_q != ST_IDLE) & ~bus_start & ~bus_stop;
   assign bit_phase = active & (bc_q < BIT_LAST);
   assign byte_done = active & (bc_q == BIT_LAST);
   assign ack_phase = active & (bc_q == BIT_ACK);
   assign addr_hit = (rx[7:1] == ID_DEV_ADDR) | (rx[7:1] == DIAG_DEV_ADDR);
   assign load_rd = ack_phase & (((state_q == ST_ADDR) & rw_q) | ((state_q == ST_RD) & ~rx[0]));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         bc_q <= 4'h0;
      end else if (bus_start) begin
         state_q <= ST_ADDR;
         bc_q <= 4'h0;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
      end else if (active) begin
         bc_q <= (bc_q == BIT_ACK) ? 4'h0 : bc_q + 4'h1;
         if (byte_done && state_q == ST_ADDR && !addr_hit) begin
            state_q <= ST_IDLE;
         end
         if (ack_phase) begin
            case (state_q)
               ST_ADDR: state_q <= rw_q ? ST_RD : ST_PTR;
               ST_PTR: state_q <= ST_WR;
               ST_RD: state_q <= rx[0] ? ST_IDLE : ST_RD;
               default: state_q <= state_q;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         page_q <= PAGE_ID;
         rw_q <= 1'b0;
      end else if (byte_done && state_q == ST_ADDR) begin
         page_q <= (rx[7:1] == DIAG_DEV_ADDR) ? PAGE_DIAG : PAGE_ID;
         rw_q <= rx[0];
      end
   end

   // ***********************
   // pointer and read data
   // ***********************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr_q <= 8'h00;
         tx_q <= 8'h00;
      end else if (byte_done && state_q == ST_PTR) begin
         ptr_q <= rx;
      end else if (byte_done && state_q == ST_WR) begin
         ptr_q <= ptr_q + 8'h01;
      end else if (load_rd) begin
         tx_q <= rd_val;
         ptr_q <= ptr_q + 8'h01;
      end else if (bit_phase && state_q == ST_RD) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // decisions are made at the rising edge and take effect at the next falling one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drive_req_q <= 1'b0;
      end else if (bus_start || bus_stop) begin
         drive_req_q <= 1'b0;
      end else if (byte_done) begin
         drive_req_q <= (state_q == ST_ADDR) ? addr_hit : (state_q != ST_RD);
      end else if (load_rd) begin
         drive_req_q <= ~rd_val[7];
      end else if (ack_phase) begin
         drive_req_q <= 1'b0;
      end else if (bit_phase && state_q == ST_RD) begin
         drive_req_q <= ~tx_q[6];
      end
   end

   // ***********************
   // writes
   // ***********************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         we_q <= 1'b0;
         wr_addr_q <= 9'h000;
         wr_data_q <= 8'h00;
      end else begin
         we_q <= byte_done && state_q == ST_WR && !is_protected(page_q, ptr_q, sync_q[0]);
         wr_addr_q <= {page_q, ptr_q};
         wr_data_q <= rx;
      end
   end

   // thresholds kept in flops so the comparators see them every cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < THR_BYTES; i++) begin
            thr_q[i] <= 8'hff;
         end
      end else if (we_q && wr_addr_q[8] == PAGE_DIAG && wr_addr_q[7:0] < OFS_THR_END) begin
         thr_q[wr_addr_q[5:0]] <= wr_data_q;
      end
   end

   mids_mem u_mem (
      .clk(clk),
      .we(we_q),
      .waddr(wr_addr_q),
      .wdata(wr_data_q),
      .raddr({page_q, ptr_q}),
      .rdata(mem_rdata)
   );

   // ***********************
   // monitors and flags
   // ***********************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int p = 0; p < NUM_MON; p++) begin
            live_q[p] <= 16'h0000;
         end
      end else begin
         live_q[0] <= mon_temp;
         live_q[1] <= mon_vcc;
         live_q[2] <= mon_bias;
         live_q[3] <= mon_txpwr;
         live_q[4] <= mon_rxpwr;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alarm_q <= 16'h0000;
         warn_q <= 16'h0000;
      end else begin
         for (int p = 0; p < NUM_MON; p++) begin
            alarm_q[15 - 2 * p] <= live_q[p] > thr16(THR_STRIDE * p + THR_HI_ALARM);
            alarm_q[14 - 2 * p] <= live_q[p] < thr16(THR_STRIDE * p + THR_LO_ALARM);
            warn_q[15 - 2 * p] <= live_q[p] > thr16(THR_STRIDE * p + THR_HI_WARN);
            warn_q[14 - 2 * p] <= live_q[p] < thr16(THR_STRIDE * p + THR_LO_WARN);
         end
      end
   end

   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_TXDIS_BIT] = sync_q[2];
      status_byte[STAT_LOS_BIT] = ~sync_q[1];
   end

   always_comb begin
      live_off = ptr_q - OFS_LIVE;
      rd_val = mem_rdata;
      if (page_q == PAGE_DIAG) begin
         if (ptr_q < OFS_THR_END) begin
            rd_val = thr_q[ptr_q[5:0]];
         end else if (ptr_q >= OFS_LIVE && ptr_q < OFS_LIVE_END) begin
            rd_val = ptr_q[0] ? live_q[live_off[3:1]][7:0] : live_q[live_off[3:1]][15:8];
         end else if (ptr_q == OFS_STATUS) begin
            rd_val = status_byte;
         end else if (ptr_q == OFS_ALARM) begin
            rd_val = alarm_q[15:8];
         end else if (ptr_q == OFS_ALARM + 8'h01) begin
            rd_val = alarm_q[7:0];
         end else if (ptr_q == OFS_WARN) begin
            rd_val = warn_q[15:8];
         end else if (ptr_q == OFS_WARN + 8'h01) begin
            rd_val = warn_q[7:0];
         end else if (ptr_q >= OFS_LIVE && ptr_q < OFS_RO_END) begin
            rd_val = 8'h00;
         end
      end else if (ptr_q == OFS_CAL_TYPE) begin
         rd_val = mem_rdata | CAL_INT_MASK;
      end
   end

   // ***********************
   // pin outputs
   // ***********************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         signal_lost_flag <= 1'b1;
         tx_laser_en <= 1'b0;
         presence_pin_out <= 1'b0;
         presence_pin_oe_n <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         signal_lost_flag <= ~sync_q[1];
         tx_laser_en <= ~sync_q[2];
         presence_pin_out <= 1'b0;
         presence_pin_oe_n <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // counts how long the laser stays on after disable is seen
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txoff_cnt_q <= '0;
      end else if (sync_q[2] && tx_laser_en) begin
         txoff_cnt_q <= txoff_cnt_q + 1'b1;
      end else begin
         txoff_cnt_q <= '0;
      end
   end

   // ***********************
   // assertions
   // ***********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_addr_byte;
      byte_done && state_q == ST_ADDR;
   endsequence
   sequence s_ack_addr;
      ack_phase && state_q == ST_ADDR;
   endsequence

   a_id_addr_ack: assert property (s_addr_byte ##0 rx[7:1] == ID_DEV_ADDR |=> drive_req_q && page_q == PAGE_ID)
      else $error("id address not acknowledged");
   a_diag_addr_ack: assert property (s_addr_byte ##0 rx[7:1] == DIAG_DEV_ADDR |=> drive_req_q && page_q == PAGE_DIAG)
      else $error("diagnostic address not acknowledged");
   a_foreign_addr: assert property (s_addr_byte ##0 !addr_hit |=> state_q == ST_IDLE && !drive_req_q)
      else $error("foreign address acknowledged");
   a_wr_guard: assert property (we_q |-> !is_protected(wr_addr_q[8], wr_addr_q[7:0], $past(sync_q[0])))
      else $error("write to protected byte");
   a_oe_at_fall: assert property ($changed(sda_oe_n) |-> ##[0:3] !scl_s)
      else $error("data line changed outside clock low");
   a_ptr_step: assert property (byte_done && state_q == ST_WR |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance after write");
   // the ack rise follows the address byte one link period later, well inside the window
   a_rd_dir: assert property (s_addr_byte ##0 (addr_hit && rx[0]) ##[1:40] s_ack_addr |=> state_q == ST_RD)
      else $error("read bit did not select read");
   a_live_temp: assert property (page_q == PAGE_DIAG && ptr_q == OFS_LIVE |-> rd_val == live_q[0][15:8])
      else $error("live temperature not shown");
   a_temp_alarm: assert property ((live_q[0] > thr16(THR_HI_ALARM))[*2] |=> alarm_q[15])
      else $error("high temperature alarm missing");
   a_los_level: assert property ((!rx_sig_det)[*4] |-> signal_lost_flag)
      else $error("signal lost not raised");
   a_txoff_bound: assert property (txoff_cnt_q < TX_OFF_CYC)
      else $error("laser still on after disable time");
   a_cal_flag: assert property (page_q == PAGE_ID && ptr_q == OFS_CAL_TYPE |-> rd_val[5])
      else $error("internal calibration not reported");
   a_tx_follow: assert property ((!tx_disable)[*4] |-> tx_laser_en)
      else $error("laser off while enabled");
   a_presence_low: assert property (!presence_pin_out && !presence_pin_oe_n)
      else $error("presence pin not driven low");
endmodule : mids_top

// ---- tb/mids_host_model.sv ----
// host two-wire master model that makes the link clock
`timescale 1ns/1ps
module mids_host_model (
   // link pins
   output logic scl,
   output logic sda_rel,
   input wire logic sda_wire
);
   // clock stands high outside frames
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // data moves only while the clock is low
   task automatic bit_out(input logic b);
      #20 sda_rel = b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
   endtask : bit_out
   task automatic bit_in(output logic b);
      #20 sda_rel = 1'b1;
      #20 scl = 1'b1;
      b = sda_wire;
      #40 scl = 1'b0;
   endtask : bit_in
   // serves as repeated start too
   task automatic start();
      #20 sda_rel = 1'b1;
      #20 scl = 1'b1;
      #40 sda_rel = 1'b0;
      #40 scl = 1'b0;
   endtask : start
   task automatic stop();
      #20 sda_rel = 1'b0;
      #20 scl = 1'b1;
      #40 sda_rel = 1'b1;
      #40;
   endtask : stop
   task automatic put(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_out(v[i]);
      end
      bit_in(ack);
   endtask : put
   task automatic get(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         bit_in(v[i]);
      end
      bit_out(last);
   endtask : get
endmodule : mids_host_model

// ---- tb/module_id_and_diag_serial_slave_tb_top.sv ----
// self-checking bench of the module id and diagnostics slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module module_id_and_diag_serial_slave_tb_top
   import mids_pkg::*;
();
   logic clk = 1'b0;
   logic rstn = 1'b1;
   logic scl, sda_rel, sda_wire, sda_out, sda_oe_n;
   logic tx_disable = 1'b1;
   logic rx_sig_det = 1'b0;
   logic id_wp = 1'b0;
   logic [15:0] mon [5];
   logic signal_lost_flag, tx_laser_en, pres_out, pres_oe_n;
   int miscompares = 0;
   int checks = 0;
   logic [31:0] seed = 32'hebd6;
   int mem [512];
   int lim [4] = '{'hc000, 'h4000, 'ha000, 'h6000};
   always #2.5 clk = ~clk;
   // open drain with pull-up
   assign sda_wire = sda_rel & (sda_oe_n | sda_out);
   mids_host_model u_host (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));
   mids_top u_dut (.clk(clk), .rstn(rstn), .scl_clk(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .tx_disable(tx_disable), .rx_sig_det(rx_sig_det), .id_wp(id_wp),
      .mon_temp(mon[0]), .mon_vcc(mon[1]), .mon_bias(mon[2]), .mon_txpwr(mon[3]), .mon_rxpwr(mon[4]),
      .signal_lost_flag(signal_lost_flag), .tx_laser_en(tx_laser_en), .presence_pin_out(pres_out),
      .presence_pin_oe_n(pres_oe_n));
   // ***********************
   // helpers
   // ***********************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic tally_and_finish();
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic addr(input logic pg, input logic rd, output logic ack);
      // host edges sit on the falling clock, away from the sampling edge
      @(negedge clk) u_host.start();
      u_host.put({pg ? DIAG_DEV_ADDR : ID_DEV_ADDR, rd}, ack);
      `CHK("addr ack", 1'b0, ack)
   endtask : addr
   // model keeps a byte only where the page allows writes
   task automatic wr(input logic pg, input int ptr, input int d[$]);
      logic ack;
      int a;
      addr(pg, 1'b0, ack);
      u_host.put(8'(ptr), ack);
      foreach (d[i]) begin
         a = (ptr + i) % 256;
         u_host.put(8'(d[i]), ack);
         `CHK("data ack", 1'b0, ack)
         if (!(pg ? (a >= 'h60 && a < 'h80) : id_wp)) begin
            mem[pg * 256 + a] = d[i] | ((!pg && a == 'h5c) ? 'h20 : 0);
         end
      end
      u_host.stop();
   endtask : wr
   // random read: pointer write, repeated start, run of bytes
   task automatic rd(input logic pg, input int ptr, input int n);
      logic ack;
      logic [7:0] v;
      int a;
      addr(pg, 1'b0, ack);
      u_host.put(8'(ptr), ack);
      addr(pg, 1'b1, ack);
      for (int i = 0; i < n; i++) begin
         a = pg * 256 + (ptr + i) % 256;
         u_host.get(i == n - 1, v);
         if (mem[a] >= 0) `CHK("read byte", 8'(mem[a]), v)
      end
      u_host.stop();
   endtask : rd
   // expected live values, status and flags
   task automatic live();
      int f, w;
      f = 0;
      w = 0;
      for (int p = 0; p < 5; p++) begin
         mem['h160 + 2 * p] = mon[p][15:8];
         mem['h161 + 2 * p] = mon[p][7:0];
         f |= (int'(mon[p] > lim[0]) << (15 - 2 * p)) | (int'(mon[p] < lim[1]) << (14 - 2 * p));
         w |= (int'(mon[p] > lim[2]) << (15 - 2 * p)) | (int'(mon[p] < lim[3]) << (14 - 2 * p));
      end
      mem['h170] = f >> 8;
      mem['h171] = f & 'hff;
      mem['h174] = w >> 8;
      mem['h175] = w & 'hff;
      mem['h16e] = {tx_disable, 5'h0, ~rx_sig_det, 1'b0};
   endtask : live
   // ***********************
   // main sequence
   // ***********************
   initial begin
      logic [31:0] r;
      logic ack;
      int q[$];
      // a real falling edge, so the link side flops reset as well
      #1 rstn <= 1'b0;
      foreach (mem[i]) mem[i] = -1;
      for (int a = 'h160; a < 'h180; a++) mem[a] = 0;
      foreach (mon[p]) mon[p] = 16'h0;
      repeat (20) @(posedge clk);
      `CHK("lost in reset", 1'b1, signal_lost_flag)
      `CHK("laser in reset", 1'b0, tx_laser_en)
      @(posedge clk) rstn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         @(posedge clk) tx_disable <= r[0];
         rx_sig_det <= r[1];
         repeat (4) @(posedge clk);
         #1;
         `CHK("laser", ~r[0], tx_laser_en)
         `CHK("lost", ~r[1], signal_lost_flag)
         `CHK("presence", 2'b00, {pres_out, pres_oe_n})
         `CHK("sda out", 1'b0, sda_out)
      end
      // id page run wraps past the top
      for (int i = 0; i < 6; i++) q.push_back(rnd() & 'hff);
      wr(PAGE_ID, 'hfd, q);
      rd(PAGE_ID, 'hfd, 6);
      wr(PAGE_ID, 'h5a, '{'h00, 'h11, 'h00, 'h33});
      rd(PAGE_ID, 'h5a, 4);
      @(posedge clk) id_wp <= 1'b1;
      repeat (4) @(posedge clk);
      wr(PAGE_ID, 'hfd, '{'h5a, 'ha5, 'h0f});
      rd(PAGE_ID, 'hfd, 6);
      @(posedge clk) id_wp <= 1'b0;
      // thresholds, then live values and flags
      q = {};
      for (int p = 0; p < 20; p++) begin
         q.push_back(lim[p % 4] >> 8);
         q.push_back(lim[p % 4] & 'hff);
      end
      wr(PAGE_DIAG, 0, q);
      rd(PAGE_DIAG, 0, 40);
      wr(PAGE_DIAG, 'h7e, '{'h12, 'h34, 'h56, 'h78});
      for (int i = 0; i < 6; i++) begin
         // first pass sits on the limits to catch an off-by-one compare
         @(posedge clk) foreach (mon[p]) mon[p] <= (i == 0) ? 16'(lim[p % 4]) : 16'(rnd());
         repeat (4) @(posedge clk);
         live();
         rd(PAGE_DIAG, 'h60, 36);
      end
      rd(PAGE_ID, 'hfd, 6);
      @(negedge clk) u_host.start();
      u_host.put(8'ha4, ack);
      `CHK("foreign addr nack", 1'b1, ack)
      u_host.stop();
      tally_and_finish();
   end
   // hang guard, well beyond the expected run
   initial begin
      #450000;
      miscompares++;
      tally_and_finish();
   end
endmodule : module_id_and_diag_serial_slave_tb_top
